//--- include/tbvc_pkg.sv
// Shared constants, register layouts and carrier types for the buck control registers
package tbvc_pkg;

   // ==========================================================
   // Channel count and register offsets
   localparam int         NUM_CH       = 3;
   localparam logic [7:0] OFS_SEL_CH1  = 8'h00;
   localparam logic [7:0] OFS_SEL_CH2  = 8'h01;
   localparam logic [7:0] OFS_SEL_CH3  = 8'h02;
   localparam logic [7:0] OFS_CMD_CH1  = 8'h03;
   localparam logic [7:0] OFS_CMD_CH2  = 8'h04;
   localparam logic [7:0] OFS_CMD_CH3  = 8'h05;
   localparam logic [7:0] OFS_SEL [NUM_CH] = '{OFS_SEL_CH1, OFS_SEL_CH2, OFS_SEL_CH3};
   localparam logic [7:0] OFS_CMD [NUM_CH] = '{OFS_CMD_CH1, OFS_CMD_CH2, OFS_CMD_CH3};
   localparam logic [7:0] RD_UNMAPPED  = 8'h00;

   // ==========================================================
   // Reset values, codes and serial bus constants
   localparam logic [7:0]  SEL_RESET     = 8'h00;
   localparam logic [7:0]  CMD_RESET     = 8'h00;
   localparam logic [6:0]  CODE_MIN      = 7'h00;
   localparam logic [6:0]  CODE_MAX      = 7'h7F;
   localparam logic [10:0] VOUT_MIN_MV   = 11'h2A8;
   localparam logic [10:0] VOUT_STEP_MV  = 11'h00A;
   localparam logic [6:0]  BUS_ADDR_DEF  = 7'h48;
   localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
   localparam int          SLEW_CNT_W    = 7;

   // ==========================================================
   // Register layouts
   typedef struct packed {
      logic       go_flag;
      logic [6:0] voltage_code;
   } tbvc_sel_s;

   typedef struct packed {
      logic       spare7;
      logic [2:0] slew_code;
      logic       spare3;
      logic       spare2;
      logic       light_load_select;
      logic       disable_n;
   } tbvc_cmd_s;

   // Per channel view handed to the converter core
   typedef struct packed {
      logic        regulate_to_code;
      logic        forced_pwm;
      logic        channel_off;
      logic [6:0]  target_code;
      logic [10:0] target_mv;
   } tbvc_chan_s;

   // One register write from the serial target
   typedef struct packed {
      logic       stb;
      logic [7:0] addr;
      logic [7:0] data;
   } tbvc_wr_s;

   // Serial target states, one-hot
   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_ADDR  = 7'h02,
      ST_REG   = 7'h04,
      ST_WDATA = 7'h08,
      ST_ACK   = 7'h10,
      ST_RDATA = 7'h20,
      ST_RACK  = 7'h40
   } tbvc_i2c_state_e;

   // Linear code to millivolt map
   function automatic logic [10:0] tbvc_code_to_mv(input logic [6:0] code);
      return 11'(VOUT_MIN_MV + VOUT_STEP_MV * {4'h0, code});
   endfunction

endpackage

//--- core/tbvc_ramp.sv
// Per channel voltage code ramp timed in switching cycles
module tbvc_ramp (
   input  wire logic                clock,
   input  wire logic                rstn,
   input  wire logic                sw_cycle,
   input  tbvc_pkg::tbvc_sel_s      sel,
   input  wire logic [2:0]          slew_code,
   input  wire logic [6:0]          startup_code,
   output logic [6:0]               target_q
);

   logic [tbvc_pkg::SLEW_CNT_W-1:0] cnt_q;
   logic [9:0]                      prev_q;
   logic [tbvc_pkg::SLEW_CNT_W-1:0] last_cnt;
   logic                            settings_moved;

   // Last tick index of one slew interval, 2^N ticks long
   assign last_cnt = tbvc_pkg::SLEW_CNT_W'((8'h01 << slew_code) - 8'h01);
   assign settings_moved = ({slew_code, sel.voltage_code} != prev_q);

   // ==========================================================
   // Settings history, used to restart the interval
   always_ff @(posedge clock)
   begin
      if (!rstn)
         prev_q <= 10'h000;
      else
         prev_q <= {slew_code, sel.voltage_code};
   end

   // ==========================================================
   // Interval counter and target stepping
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         target_q <= tbvc_pkg::CODE_MIN;
         cnt_q    <= '0;
      end
      else if (!sel.go_flag)
      begin
         target_q <= startup_code;
         cnt_q    <= '0;
      end
      else if (settings_moved || target_q == sel.voltage_code)
         cnt_q <= '0;
      else if (sw_cycle)
      begin
         if (cnt_q == last_cnt)
         begin
            cnt_q <= '0;
            if (target_q < sel.voltage_code)
               target_q <= 7'(target_q + 7'h01);
            else
               target_q <= 7'(target_q - 7'h01);
         end
         else
            cnt_q <= tbvc_pkg::SLEW_CNT_W'(cnt_q + 1'h1);
      end
   end

endmodule

//--- core/tbvc_top.sv
// Serial target, control registers and voltage ramps of the triple buck controller
//
// How it works
// - Go flag bit 7, reset 0, gates code
// - Seven bit voltage code, reset zero
// - Code maps linearly, 0.68 V plus 10 mV
// - Command bits 6..4 hold slew code
// - One 10 mV step per 2^N cycles
// - Bit 1 forces fixed frequency operation
// - Bit 0 high switches channel off
// - Bits 7,3,2 plain storage, reset zero
// - Three channels, identical independent layouts
// - Write: address, register, data; acked bytes
// - All hardware enables low blocks updates
module tbvc_top #(
   parameter logic [6:0] BUS_ADDR = tbvc_pkg::BUS_ADDR_DEF
) (
   input  wire logic                 clock,
   input  wire logic                 rstn,
   input  wire logic                 scl_in,
   input  wire logic                 sda_in,
   output logic                      sda_out,
   output logic                      sda_oe,
   input  wire logic [2:0]           hw_enable,
   input  wire logic                 sw_cycle,
   input  wire logic [6:0]           startup_code [tbvc_pkg::NUM_CH],
   output tbvc_pkg::tbvc_chan_s      chan_out [tbvc_pkg::NUM_CH]
);

   // ==========================================================
   // Declarations
   tbvc_pkg::tbvc_i2c_state_e state_q;
   tbvc_pkg::tbvc_i2c_state_e next_q;
   logic                      scl_q;
   logic                      sda_q;
   logic                      sda_oe_q;
   logic                      sda_out_q;
   logic [3:0]                bit_q;
   logic [7:0]                shift_q;
   logic [7:0]                ptr_q;
   logic                      mack_q;
   tbvc_pkg::tbvc_wr_s        wr_q;
   logic [7:0]                rd_data;
   logic                      scl_rise;
   logic                      scl_fall;
   logic                      bus_start;
   logic                      bus_stop;
   logic                      writes_allowed;
   tbvc_pkg::tbvc_sel_s       sel_q [tbvc_pkg::NUM_CH];
   tbvc_pkg::tbvc_cmd_s       cmd_q [tbvc_pkg::NUM_CH];
   logic [6:0]                target [tbvc_pkg::NUM_CH];
   logic [10:0]               mv_q [tbvc_pkg::NUM_CH];

   // ==========================================================
   // Bus line history and condition detection
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         scl_q <= 1'h1;
         sda_q <= 1'h1;
      end
      else
      begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   // Start and stop are data moves while the clock line stays high
   assign scl_rise  = scl_in & ~scl_q;
   assign scl_fall  = ~scl_in & scl_q;
   assign bus_start = scl_in & scl_q & sda_q & ~sda_in;
   assign bus_stop  = scl_in & scl_q & ~sda_q & sda_in;

   // hardware shutdown blocks
   // Software shutdown leaves this untouched, so the bus stays usable
   assign writes_allowed = |hw_enable;

   // ==========================================================
   // Open drain data line: only ever pulled low
   always_ff @(posedge clock)
   begin
      if (!rstn)
         sda_out_q <= 1'h0;
      else
         sda_out_q <= 1'h0;
   end

   assign sda_out = sda_out_q;
   assign sda_oe  = sda_oe_q;

   // ==========================================================
   // Serial target state machine
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         state_q  <= tbvc_pkg::ST_IDLE;
         next_q   <= tbvc_pkg::ST_IDLE;
         bit_q    <= 4'h0;
         shift_q  <= 8'h00;
         ptr_q    <= 8'h00;
         mack_q   <= 1'h0;
         sda_oe_q <= 1'h0;
         wr_q     <= '0;
      end
      else
      begin
         wr_q.stb <= 1'h0;
         // A stop anywhere ends the transfer and frees the line
         if (bus_stop)
         begin
            state_q  <= tbvc_pkg::ST_IDLE;
            sda_oe_q <= 1'h0;
         end
         // Repeated start is taken in any state
         else if (bus_start)
         begin
            state_q  <= tbvc_pkg::ST_ADDR;
            bit_q    <= 4'h0;
            sda_oe_q <= 1'h0;
         end
         else
         begin
            case (state_q)
               tbvc_pkg::ST_IDLE:
                  sda_oe_q <= 1'h0;
               tbvc_pkg::ST_ADDR,
               tbvc_pkg::ST_REG,
               tbvc_pkg::ST_WDATA:
               begin
                  // Bits are sampled while the clock is high, msb first
                  if (scl_rise && bit_q != tbvc_pkg::BITS_PER_BYTE)
                  begin
                     shift_q <= {shift_q[6:0], sda_in};
                     bit_q   <= 4'(bit_q + 4'h1);
                  end
                  else if (scl_fall && bit_q == tbvc_pkg::BITS_PER_BYTE)
                  begin
                     bit_q    <= 4'h0;
                     sda_oe_q <= 1'h1;
                     state_q  <= tbvc_pkg::ST_ACK;
                     if (state_q == tbvc_pkg::ST_ADDR)
                     begin
                        // Foreign address: stay silent until the next start
                        if (shift_q[7:1] != BUS_ADDR)
                        begin
                           sda_oe_q <= 1'h0;
                           state_q  <= tbvc_pkg::ST_IDLE;
                        end
                        else if (shift_q[0])
                           next_q <= tbvc_pkg::ST_RDATA;
                        else
                           next_q <= tbvc_pkg::ST_REG;
                     end
                     else if (state_q == tbvc_pkg::ST_REG)
                     begin
                        ptr_q  <= shift_q;
                        next_q <= tbvc_pkg::ST_WDATA;
                     end
                     else
                     begin
                        wr_q.stb  <= writes_allowed;
                        wr_q.addr <= ptr_q;
                        wr_q.data <= shift_q;
                        ptr_q     <= 8'(ptr_q + 8'h01);
                        next_q    <= tbvc_pkg::ST_WDATA;
                     end
                  end
               end
               tbvc_pkg::ST_ACK:
               begin
                  // Acknowledge ends at the clock's next fall
                  if (scl_fall)
                  begin
                     state_q <= next_q;
                     if (next_q == tbvc_pkg::ST_RDATA)
                     begin
                        shift_q  <= rd_data;
                        sda_oe_q <= ~rd_data[7];
                        bit_q    <= 4'h1;
                        ptr_q    <= 8'(ptr_q + 8'h01);
                     end
                     else
                        sda_oe_q <= 1'h0;
                  end
               end
               tbvc_pkg::ST_RDATA:
               begin
                  // Next bit goes out on each fall of the clock
                  if (scl_fall)
                  begin
                     if (bit_q == tbvc_pkg::BITS_PER_BYTE)
                     begin
                        sda_oe_q <= 1'h0;
                        state_q  <= tbvc_pkg::ST_RACK;
                     end
                     else
                     begin
                        sda_oe_q <= ~shift_q[6];
                        shift_q  <= {shift_q[6:0], 1'h0};
                        bit_q    <= 4'(bit_q + 4'h1);
                     end
                  end
               end
               tbvc_pkg::ST_RACK:
               begin
                  // Controller acknowledge asks for another byte
                  if (scl_rise)
                     mack_q <= ~sda_in;
                  else if (scl_fall)
                  begin
                     if (mack_q)
                     begin
                        shift_q  <= rd_data;
                        sda_oe_q <= ~rd_data[7];
                        bit_q    <= 4'h1;
                        ptr_q    <= 8'(ptr_q + 8'h01);
                        state_q  <= tbvc_pkg::ST_RDATA;
                     end
                     else
                        state_q <= tbvc_pkg::ST_IDLE;
                  end
               end
               default:
               begin
                  state_q  <= tbvc_pkg::ST_IDLE;
                  sda_oe_q <= 1'h0;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Read data selection; unmapped addresses read as zero
   always_comb
   begin
      rd_data = tbvc_pkg::RD_UNMAPPED;
      for (int ch = 0; ch < tbvc_pkg::NUM_CH; ch++)
      begin
         if (ptr_q == tbvc_pkg::OFS_SEL[ch])
            rd_data = sel_q[ch];
         if (ptr_q == tbvc_pkg::OFS_CMD[ch])
            rd_data = cmd_q[ch];
      end
   end

   // ==========================================================
   // Per channel registers, ramps and outputs
   // identical per channel
   for (genvar ch = 0; ch < tbvc_pkg::NUM_CH; ch++)
   begin : g_ch
      always_ff @(posedge clock)
      begin
         if (!rstn)
            sel_q[ch] <= tbvc_pkg::SEL_RESET;
         else if (wr_q.stb && wr_q.addr == tbvc_pkg::OFS_SEL[ch])
            sel_q[ch] <= wr_q.data;
      end

      always_ff @(posedge clock)
      begin
         if (!rstn)
            cmd_q[ch] <= tbvc_pkg::CMD_RESET;
         else if (wr_q.stb && wr_q.addr == tbvc_pkg::OFS_CMD[ch])
            cmd_q[ch] <= wr_q.data;
      end

      tbvc_ramp u_ramp (
         .clock        (clock),
         .rstn         (rstn),
         .sw_cycle     (sw_cycle),
         .sel          (sel_q[ch]),
         .slew_code    (cmd_q[ch].slew_code),
         .startup_code (startup_code[ch]),
         .target_q     (target[ch])
      );

      // linear millivolt map
      // Lags the ramp by one clock, far below any converter response
      always_ff @(posedge clock)
      begin
         if (!rstn)
            mv_q[ch] <= tbvc_pkg::VOUT_MIN_MV;
         else
            mv_q[ch] <= tbvc_pkg::tbvc_code_to_mv(target[ch]);
      end

      assign chan_out[ch].regulate_to_code = sel_q[ch].go_flag;
      assign chan_out[ch].forced_pwm       = cmd_q[ch].light_load_select;
      assign chan_out[ch].channel_off      = cmd_q[ch].disable_n;
      assign chan_out[ch].target_code      = target[ch];
      assign chan_out[ch].target_mv        = mv_q[ch];
   end

endmodule

//--- tb/tbvc_monitor.sv
// Port checks for the buck control register block
module tbvc_monitor (
   input wire logic            clock,
   input wire logic            rstn,
   input wire logic            scl_in,
   input wire logic            sda_in,
   input wire logic            sda_out,
   input wire logic            sda_oe,
   input wire logic [2:0]      hw_enable,
   input wire logic            sw_cycle,
   input wire logic [6:0]      startup_code [tbvc_pkg::NUM_CH],
   input tbvc_pkg::tbvc_chan_s chan_out [tbvc_pkg::NUM_CH]
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Serial line
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   chk_sda_low_only:
   assert property (sda_out == 1'b0)
      else $error("data drive value not zero");
   // Drive moves only just after a clock fall
   chk_oe_on_fall:
   assert property ($changed(sda_oe) |-> !$past(scl_in) && $past(scl_in, 2))
      else $error("data drive moved away from a clock fall");
   chk_oe_stands:
   assert property ($rose(sda_oe) |-> sda_oe [*6])
      else $error("data drive released too early");

   // ==========================================================
   // Channels
   for (genvar c = 0; c < tbvc_pkg::NUM_CH; c++)
   begin
      chk_reset_state:
      assert property ($rose(rstn) |-> !chan_out[c].regulate_to_code
         && !chan_out[c].forced_pwm && !chan_out[c].channel_off)
         else $error("channel not at reset state");
      chk_mv_map:
      assert property (chan_out[c].target_mv
         == 11'h2A8 + 11'h00A * {4'h0, $past(chan_out[c].target_code)})
         else $error("millivolt value off the code map");
      chk_startup_track:
      assert property ($past(rstn) && !$past(chan_out[c].regulate_to_code)
         |-> chan_out[c].target_code == $past(startup_code[c]))
         else $error("target left startup code while go low");
      // A step needs a switching pulse and moves one code only
      chk_one_step:
      assert property ($past(chan_out[c].regulate_to_code)
         && $changed(chan_out[c].target_code) |-> ($past(sw_cycle) || $past(sw_cycle, 2))
         && ((chan_out[c].target_code - $past(chan_out[c].target_code)) inside {7'h01, 7'h7F}))
         else $error("target moved without pulse or by more than one");
      chk_field_on_ack:
      assert property ($changed({chan_out[c].regulate_to_code, chan_out[c].forced_pwm,
         chan_out[c].channel_off}) |-> $past(sda_oe) && $past(hw_enable) != 3'h0)
         else $error("field changed outside an accepted write");
   end

   cov_ack: cover property ($rose(sda_oe));
   cov_step: cover property (chan_out[0].regulate_to_code && $changed(chan_out[0].target_code));
   cov_off: cover property ($rose(chan_out[0].channel_off));
endmodule

bind tbvc_top tbvc_monitor u_mon (
   .clock(clock),
   .rstn(rstn),
   .scl_in(scl_in),
   .sda_in(sda_in),
   .sda_out(sda_out),
   .sda_oe(sda_oe),
   .hw_enable(hw_enable),
   .sw_cycle(sw_cycle),
   .startup_code(startup_code),
   .chan_out(chan_out)
);

//--- tb/tbvc_host.sv
// Two-wire bus controller model for the register block
module tbvc_host (
   input wire logic clock,
   input wire logic sda,
   output logic     scl,
   output logic     sda_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus, both lines released high
   initial
   begin
      scl = 1'b1;
      sda_o = 1'b1;
   end

   // Four cycle phase keeps above the three cycle minimum
   task automatic half();
      repeat (4) @(negedge clock);
   endtask

   // Data only changes while the clock line is low
   task automatic bit_io(input logic b, output logic r);
      sda_o = b;
      half();
      scl = 1'b1;
      half();
      r = sda;
      scl = 1'b0;
      half();
   endtask

   task automatic start();
      sda_o = 1'b1;
      half();
      scl = 1'b1;
      half();
      sda_o = 1'b0;
      half();
      scl = 1'b0;
      half();
   endtask

   task automatic stop();
      sda_o = 1'b0;
      half();
      scl = 1'b1;
      half();
      sda_o = 1'b1;
      half();
   endtask

   task automatic byte_w(input logic [7:0] d, inout logic ok);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ok = ok & ~r;
   endtask

   // One byte read; a low acknowledge asks for more, high ends the read
   task automatic byte_r(output logic [7:0] d, input logic nack);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, d[i]);
      end
      bit_io(nack, r);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] ra, input logic [7:0] d,
                     output logic ok);
      ok = 1'b1;
      start();
      byte_w({a, 1'b0}, ok);
      byte_w(ra, ok);
      byte_w(d, ok);
      stop();
   endtask

   // Pointer write, repeated start, then one byte back
   task automatic rd(input logic [6:0] a, input logic [7:0] ra, output logic [7:0] d);
      logic ok;
      ok = 1'b1;
      start();
      byte_w({a, 1'b0}, ok);
      byte_w(ra, ok);
      start();
      byte_w({a, 1'b1}, ok);
      byte_r(d, 1'b1);
      stop();
   endtask

   // Two bytes back from consecutive registers, acknowledged in between
   task automatic rd2(input logic [6:0] a, input logic [7:0] ra, output logic [15:0] d);
      logic ok;
      ok = 1'b1;
      start();
      byte_w({a, 1'b0}, ok);
      byte_w(ra, ok);
      start();
      byte_w({a, 1'b1}, ok);
      byte_r(d[15:8], 1'b0);
      byte_r(d[7:0], 1'b1);
      stop();
   endtask
endmodule

//--- tb/tb_tbvc_top.sv
// Self-checking bench for the buck control register block
module tb_tbvc_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] ADR = tbvc_pkg::BUS_ADDR_DEF;
   logic                 clock;
   logic                 rstn;
   logic                 scl;
   logic                 sda_o;
   logic                 sda;
   logic                 sda_out;
   logic                 sda_oe;
   logic [2:0]           hw_enable;
   logic                 sw_cycle;
   logic [6:0]           startup_code [tbvc_pkg::NUM_CH];
   tbvc_pkg::tbvc_chan_s chan_out [tbvc_pkg::NUM_CH];
   logic [7:0]           rdat;
   logic                 ok;
   int                   n_errors = 0;
   int                   cmp_count = 0;
   int                   cycles = 0;

   // Open-drain data line with pull-up
   assign sda = sda_o & ~sda_oe;

   tbvc_top #(.BUS_ADDR(ADR)) uut (.clock(clock), .rstn(rstn), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .hw_enable(hw_enable), .sw_cycle(sw_cycle),
      .startup_code(startup_code), .chan_out(chan_out));
   tbvc_host host (.clock(clock), .sda(sda), .scl(scl), .sda_o(sda_o));

   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // Hang guard, well above the expected run length
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         n_errors = n_errors + 1;
         summarize();
      end
   end

   task automatic summarize();
      $display("mismatches %0d of %0d compares", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
      begin
         $display("ALL CHECKS OK");
      end
      else
      begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [10:0] got, input logic [10:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask

   // Pulses spaced so no pulse lands in a restart cycle
   task automatic pulses(input int n);
      repeat (n)
      begin
         sw_cycle = 1'b1;
         @(negedge clock);
         sw_cycle = 1'b0;
         repeat (3) @(negedge clock);
      end
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      for (int r = 0; r < 7; r++)
      begin
         host.rd(ADR, 8'(r), rdat);
         check("reset reg", 11'(rdat), 11'h000);
      end
      check("mv min", chan_out[1].target_mv, 11'h2A8);
      check("mv max", chan_out[2].target_mv, 11'h79E);
   endtask

   task automatic t_rw();
      logic [7:0] v [6] = '{8'h05, 8'h06, 8'h07, 8'h8D, 8'h72, 8'h4E};
      logic [15:0] pair;
      for (int r = 0; r < 6; r++)
      begin
         host.wr(ADR, 8'(r), v[r], ok);
         check("ack", 11'(ok), 11'h001);
      end
      for (int r = 0; r < 6; r++)
      begin
         host.rd(ADR, 8'(r), rdat);
         check("readback", 11'(rdat), 11'(v[r]));
      end
      // Burst read walks the pointer across two command registers
      host.rd2(ADR, 8'h03, pair);
      check("burst first", 11'(pair[15:8]), 11'(v[3]));
      check("burst second", 11'(pair[7:0]), 11'(v[4]));
      for (int c = 0; c < 3; c++)
      begin
         check("pwm", 11'(chan_out[c].forced_pwm), 11'(v[c + 3][1]));
         check("off", 11'(chan_out[c].channel_off), 11'(v[c + 3][0]));
         check("go low", 11'(chan_out[c].regulate_to_code), 11'(v[c][7]));
      end
   endtask

   // Writes still acked but dropped while all enables are low
   task automatic t_hw();
      hw_enable = 3'h0;
      host.wr(ADR, 8'h05, 8'h11, ok);
      check("hw ack", 11'(ok), 11'h001);
      hw_enable = 3'h4;
      host.wr(ADR ^ 7'h01, 8'h04, 8'h33, ok);
      check("nack", 11'(ok), 11'h000);
      host.rd(ADR, 8'h05, rdat);
      check("hw drop", 11'(rdat), 11'h04E);
      host.rd(ADR, 8'h04, rdat);
      check("adr drop", 11'(rdat), 11'h072);
   endtask

   // Every slew code: 2^N-1 pulses hold, the next one steps
   task automatic t_ramp();
      logic [6:0] cur;
      logic [6:0] nxt;
      cur = startup_code[0];
      for (int n = 0; n < 8; n++)
      begin
         nxt = n[0] ? cur - 7'h01 : cur + 7'h01;
         host.wr(ADR, 8'h03, {1'b0, 3'(n), 4'h0}, ok);
         host.wr(ADR, 8'h00, {1'b1, nxt}, ok);
         check("go", 11'(chan_out[0].regulate_to_code), 11'h001);
         pulses((1 << n) - 1);
         check("hold", 11'(chan_out[0].target_code), 11'(cur));
         pulses(1);
         check("step", 11'(chan_out[0].target_code), 11'(nxt));
         check("mv", chan_out[0].target_mv, 11'h2A8 + 11'h00A * 11'(nxt));
         cur = nxt;
      end
   endtask

   // Slew change mid interval must restart the count from zero
   task automatic t_restart();
      host.wr(ADR, 8'h03, 8'h20, ok);
      host.wr(ADR, 8'h00, 8'hC2, ok);
      pulses(2);
      host.wr(ADR, 8'h03, 8'h30, ok);
      pulses(7);
      check("restart hold", 11'(chan_out[0].target_code), 11'h040);
      pulses(1);
      check("restart step", 11'(chan_out[0].target_code), 11'h041);
   endtask

   initial
   begin
      rstn = 1'b0;
      sw_cycle = 1'b0;
      hw_enable = 3'h7;
      startup_code = '{7'h40, 7'h00, 7'h7F};
      repeat (12) @(negedge clock);
      rstn = 1'b1;
      repeat (3) @(negedge clock);
      t_reset();
      t_rw();
      t_hw();
      t_ramp();
      t_restart();
      summarize();
   end
endmodule
